// ===== tape_coupler_cfg.svh
`ifndef TAPE_COUPLER_CFG_SVH
`define TAPE_COUPLER_CFG_SVH

// Register word offsets on the device port
`define DATA_BUF_OFFSET    3'h0
`define STATUS_OFFSET      3'h2
`define OFFSET_W           3

// Packet-free bootstrap trigger value (octal 100001)
`define BOOT_VALUE         16'h8001

// Termination classes
`define TC_NORMAL          3'h0
`define TC_RECOVER_MOVED   3'h4
`define TC_RECOVER_STILL   3'h5
`define TC_FATAL           3'h7

// Reset values
`define TC_RESET           3'h0
`define ADDR_LO_RESET      16'h0000
`define ADDR_HI_RESET      2'h0
`define PTR_RESET          18'h00000
`define RDATA_RESET        16'h0000

`endif

// ===== tape_coupler_pkg.sv
package tape_coupler_pkg;

    typedef enum logic [1:0] {
        st_ready   = 2'b00,
        st_busy    = 2'b01,
        st_loading = 2'b10,
        st_halted  = 2'b11
    } coupler_state_e;

    typedef logic [2:0]  term_class_t;
    typedef logic [15:0] bus_word_t;
    typedef logic [17:0] phys_addr_t;

endpackage : tape_coupler_pkg

// ===== status_flag.sv
`timescale 1ns/1ps

// Sticky status bit: a set in the same cycle as a clear wins
module status_flag (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);

    wire next_q = set | (q & ~clr);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    set_wins_a: assert property (@(posedge mclk) disable iff (rst) set |=> q)
        else $error("flag set was lost");

    clear_works_a: assert property (@(posedge mclk) disable iff (rst) (clr && !set) |=> !q)
        else $error("flag clear was ignored");

endmodule : status_flag

// ===== tape_coupler_status_register.sv
// Overview of operation
// R1 - 16-bit status word readable at base plus two
// R2 - Pointer write clears parity, refused, memory, ready
// R3 - Status word write initializes coupler and drive
// R4 - Bits 14-11 and 7 cleared only by listed events
// R5 - Bits 15, 7 coupler; 10, 6-0 track subsystem
// R6 - Bits 3-1 carry eight termination classes
// R7 - Class 7: buffer-needed flag tells message validity
// R8 - Refused flag sets special condition, class unchanged
// R9 - Pointer written while not ready sets refused
// R10 - No status refresh while attention off, buffer held
// R11 - After initialize, update only at load point
// R12 - Special condition marks error or exception end
// R13 - Host parity error flagged with class 4/5
// R14 - Missing memory flagged with class 4/5
// R15 - Buffer-needed set by initialize, cleared by characteristics
// R16 - Bits 9 and 8 mirror readback bits 17, 16
// R17 - Ready set only while idle for pointers
// R18 - Offline bit shows drive cannot move tape
// R19 - Host trusts class field only with bit 15
// R20 - Two bootstrap writes read second record to zero
// R21 - Pointer formed from bus bits, low two zero
// R22 - Bits 13, 5, 4 and 0 read zero
`timescale 1ns/1ps
`include "tape_coupler_cfg.svh"

module tape_coupler_status_register #(
    parameter int ADDR_W = 18
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        bus_sel,
    input  wire logic                        bus_wr,
    input  wire logic                        bus_rd,
    input  wire logic                        bus_byte,
    input  wire logic [`OFFSET_W-1:0]        bus_addr,
    input  wire tape_coupler_pkg::bus_word_t bus_wdata,
    output tape_coupler_pkg::bus_word_t      bus_rdata,
    output logic                             bus_ack,
    input  wire logic                        bus_init,
    input  wire logic                        drive_power_up,
    input  wire logic                        drive_online,
    input  wire logic                        load_point,
    input  wire logic                        attention_message_enable,
    input  wire logic                        msg_released,
    input  wire logic                        seq_done,
    input  wire tape_coupler_pkg::term_class_t seq_tc,
    input  wire logic                        seq_special,
    input  wire logic                        seq_host_parity,
    input  wire logic                        seq_secondary_parity,
    input  wire logic                        seq_nxm,
    input  wire logic                        seq_buffer_valid,
    input  wire tape_coupler_pkg::phys_addr_t seq_end_addr,
    output tape_coupler_pkg::phys_addr_t     cmd_pointer,
    output logic                             cmd_start,
    output logic                             subsys_init,
    output logic                             auto_load,
    output logic                             boot_start,
    output logic                             secondary_parity_flag
);
    import tape_coupler_pkg::*;

    if (ADDR_W != 18) begin : g_width_check
        $error("command pointer logic serves 18 address bits only");
    end

    coupler_state_e state;
    coupler_state_e next_state;

    term_class_t tc;
    logic        sc;
    logic        offline;
    logic        needs_message_buffer;
    logic [1:0]  addr_hi;
    bus_word_t   addr_lo;
    logic        boot_armed;
    logic        boot_first;
    logic        host_parity;
    logic        refused;
    logic        missing_mem;

    // Bus decode on the word part: bit 0 only picks the odd byte of a byte write
    wire acc_db   = bus_sel && ({bus_addr[`OFFSET_W-1:1], 1'b0} == `DATA_BUF_OFFSET);
    wire acc_sw   = bus_sel && ({bus_addr[`OFFSET_W-1:1], 1'b0} == `STATUS_OFFSET);
    wire wr_db    = acc_db && bus_wr;
    wire wr_sw    = acc_sw && bus_wr;
    wire ptr_wr   = wr_db && !bus_byte;
    wire maint_wr = wr_db && bus_byte;
    wire any_db   = ptr_wr || maint_wr;
    wire is_ready = (state == st_ready);

    // Initialize sources: status write, bus init, drive power-up
    wire init_evt  = wr_sw || bus_init || drive_power_up;                   // see R3
    // Offline drive has nothing to load, so it completes at once
    wire init_done = (init_evt && !drive_online) ||
                     (!init_evt && state == st_loading && load_point);      // see R11

    // Status refresh is withheld to keep message ordering intact
    wire refresh_ok  = attention_message_enable || msg_released;                         // see R10
    wire tc_update   = seq_done && refresh_ok;
    wire recov_class = (seq_tc == `TC_RECOVER_MOVED) ||
                       (seq_tc == `TC_RECOVER_STILL);

    wire refuse_set  = any_db && !is_ready;                                 // see R9
    wire flag_clr    = init_done || any_db;                                 // see R2 see R4
    wire parity_set  = seq_done && seq_host_parity && recov_class;          // see R13
    wire nxm_set     = seq_done && seq_nxm && recov_class;                  // see R14
    wire spe_set     = seq_done && seq_secondary_parity;

    // Pointer: bus 15..2 in place, bus 1..0 become address 17..16
    wire phys_addr_t new_ptr = {bus_wdata[1:0], bus_wdata[15:2], 2'b00};    // see R21

    // Bootstrap detection
    wire boot_word = wr_sw && !bus_byte && (bus_wdata == `BOOT_VALUE);
    wire boot_hit  = boot_word && boot_armed && boot_first;                 // see R20

    // Status word image, fixed-zero bits kept zero
    wire bus_word_t status_word = {sc, host_parity, 1'b0, refused,
                                   missing_mem, needs_message_buffer, addr_hi,
                                   is_ready, offline, 2'b00, tc, 1'b0};     // see R1 see R5 see R22
    wire bus_word_t read_mux = acc_sw ? status_word :
                               acc_db ? addr_lo : `RDATA_RESET;

    always_comb begin
        next_state = state;
        case (state)
            st_ready: begin
                if (ptr_wr) begin
                    next_state = st_busy;
                end else if (maint_wr) begin
                    next_state = st_halted;
                end
            end
            st_busy: begin
                if (seq_done) begin
                    next_state = st_ready;
                end
            end
            st_loading: begin
                if (load_point) begin
                    next_state = st_ready;
                end
            end
            st_halted: begin
                next_state = st_halted;
            end
            default: begin
                next_state = st_ready;
            end
        endcase
        // Initialize overrides any state
        if (init_evt) begin
            next_state = drive_online ? st_loading : st_ready;
        end
        if (boot_hit) begin
            next_state = st_busy;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= st_ready;
        end else begin
            state <= next_state;                                            // see R17
        end
    end

    status_flag u_host_parity (
        .mclk (mclk),
        .rst  (rst),
        .set  (parity_set),
        .clr  (flag_clr),
        .q    (host_parity)
    );

    status_flag u_refused (
        .mclk (mclk),
        .rst  (rst),
        .set  (refuse_set),
        .clr  (flag_clr),
        .q    (refused)
    );

    status_flag u_missing_mem (
        .mclk (mclk),
        .rst  (rst),
        .set  (nxm_set),
        .clr  (flag_clr),
        .q    (missing_mem)
    );

    status_flag u_secondary_parity (
        .mclk (mclk),
        .rst  (rst),
        .set  (spe_set),
        .clr  (flag_clr),
        .q    (secondary_parity_flag)
    );

    // Special condition and termination class
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sc <= 1'b0;
            tc <= `TC_RESET;
        end else begin
            if (init_done) begin
                sc <= 1'b0;
                tc <= `TC_NORMAL;
            end else if (ptr_wr && is_ready) begin
                sc <= 1'b0;
            end
            if (tc_update) begin
                sc <= seq_special;                                          // see R12
                tc <= seq_tc;                                               // see R6
            end
            if (refuse_set) begin
                sc <= 1'b1;                                                 // see R8
            end
        end
    end

    // Offline and buffer-needed track the subsystem
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            offline <= 1'b0;
            needs_message_buffer     <= 1'b1;
        end else begin
            if (refresh_ok || init_done) begin
                offline <= !drive_online;                                   // see R18
            end
            if (init_done) begin
                needs_message_buffer <= 1'b1;                                                // see R15
            end else if (seq_buffer_valid) begin
                needs_message_buffer <= 1'b0;                                                // see R7
            end
        end
    end

    // Address readback, survives initialize
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_lo <= `ADDR_LO_RESET;
            addr_hi <= `ADDR_HI_RESET;
        end else if (maint_wr && bus_addr[0]) begin
            addr_lo <= {bus_wdata[15:8], bus_wdata[15:8]};
            addr_hi <= bus_wdata[9:8];
        end else if (maint_wr) begin
            addr_lo <= bus_wdata;
        end else if (seq_done) begin
            addr_lo <= seq_end_addr[15:0];
            addr_hi <= seq_end_addr[17:16];                                 // see R16
        end
    end

    // Command pointer and start pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_pointer <= `PTR_RESET;
            cmd_start   <= 1'b0;
        end else begin
            cmd_start <= ptr_wr && is_ready && !init_evt;
            if (ptr_wr) begin
                cmd_pointer <= new_ptr;                                     // see R21
            end
        end
    end

    // Bootstrap arming: only reset or bus init arm it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            boot_armed <= 1'b1;
            boot_first <= 1'b0;
        end else if (bus_init) begin
            boot_armed <= 1'b1;
            boot_first <= 1'b0;
        end else if (wr_sw) begin
            boot_first <= boot_word && boot_armed && !boot_first;
            boot_armed <= boot_word && boot_armed && !boot_first;           // see R20
        end
    end

    // Initialize, load and bootstrap pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            subsys_init <= 1'b0;
            auto_load   <= 1'b0;
            boot_start  <= 1'b0;
        end else begin
            subsys_init <= init_evt;                                        // see R3
            auto_load   <= init_evt && drive_online;
            boot_start  <= boot_hit;
        end
    end

    // Bus answer one cycle after the access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_rdata <= `RDATA_RESET;
            bus_ack   <= 1'b0;
        end else begin
            bus_ack <= bus_sel && (bus_rd || bus_wr);
            if (bus_sel && bus_rd) begin
                bus_rdata <= read_mux;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    refuse_busy_a: assert property ((ptr_wr && !is_ready) |=> refused)   // see R9
        else $error("pointer while busy did not set refused");

    refuse_sc_a: assert property ((refuse_set && !tc_update && !init_done) |=> (sc && $stable(tc))) // see R8
        else $error("refused did not raise special condition");

    ptr_format_a: assert property (ptr_wr |=> cmd_pointer ==               // see R21
        {$past(bus_wdata[1:0]), $past(bus_wdata[15:2]), 2'b00})
        else $error("command pointer misformed");

    write_init_a: assert property (wr_sw |=> subsys_init)                 // see R3
        else $error("status write did not initialize");

    pointer_clear_a: assert property ((ptr_wr && is_ready && !seq_done && !init_evt) |=> // see R2
        (!refused && !host_parity && !missing_mem && !is_ready))
        else $error("pointer write did not clear flags");

    stale_hold_a: assert property ((seq_done && !refresh_ok && !init_done) |=> // see R10
        $stable(tc))
        else $error("class refreshed while withheld");

    load_wait_a: assert property ((state == st_loading && !load_point && !init_evt // see R11
        && !boot_hit) |=> (state == st_loading && !is_ready))
        else $error("left loading before load point");

    nba_init_a: assert property (init_done |=> needs_message_buffer)                       // see R15
        else $error("buffer-needed not set after initialize");

    zero_bits_a: assert property ((bus_sel && bus_rd && acc_sw) |=>        // see R22 see R16
        (bus_rdata[13] == 1'b0 && bus_rdata[5:4] == 2'b00 && bus_rdata[0] == 1'b0 &&
         bus_rdata[9:8] == $past(addr_hi)))
        else $error("status word fixed bits or mirror wrong");

    boot_pulse_a: assert property (boot_start |-> $past(boot_word))       // see R20
        else $error("bootstrap without bootstrap write");

endmodule : tape_coupler_status_register

// ===== host_bus_model.sv
`timescale 1ns/1ps

// Host side of the register bus: one access at a time, changed on the falling edge
module host_bus_model (
    input  wire logic                        mclk,
    input  wire logic                        bus_ack,
    input  wire tape_coupler_pkg::bus_word_t bus_rdata,
    output logic                             bus_sel,
    output logic                             bus_wr,
    output logic                             bus_rd,
    output logic                             bus_byte,
    output logic [2:0]                       bus_addr,
    output tape_coupler_pkg::bus_word_t      bus_wdata
);
    import tape_coupler_pkg::*;

    int lost = 0;

    initial begin
        bus_sel   = 1'b0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_byte  = 1'b0;
        bus_addr  = 3'h0;
        bus_wdata = 16'h0000;
    end

    task automatic access(input logic wr, input logic byt, input logic [2:0] addr,
                          input bus_word_t wd, output bus_word_t rd);
        int n;
        n = 0;
        @(negedge mclk);
        bus_sel   = 1'b1;
        bus_wr    = wr;
        bus_rd    = ~wr;
        bus_byte  = byt;
        bus_addr  = addr;
        bus_wdata = wd;
        @(negedge mclk);
        bus_sel   = 1'b0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_byte  = 1'b0;
        // Released data lines must not keep looking valid
        bus_wdata = ~wd;
        while (bus_ack !== 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        if (bus_ack !== 1'b1)
            lost++;
        rd = bus_rdata;
    endtask : access

    // Class field is only trusted while special condition is set
    function automatic term_class_t class_of(input bus_word_t sw);
        return sw[15] ? sw[3:1] : 3'h0;
    endfunction : class_of
endmodule : host_bus_model

// ===== test_tape_coupler_status_register.sv
`timescale 1ns/1ps
`include "tape_coupler_cfg.svh"

module test_tape_coupler_status_register;
    import tape_coupler_pkg::*;

    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        bus_sel, bus_wr, bus_rd, bus_byte, bus_ack;
    logic [2:0]  bus_addr;
    bus_word_t   bus_wdata, bus_rdata, rd;
    logic        bus_init, drive_power_up, drive_online, load_point, attention_message_enable, msg_released;
    logic        seq_done, seq_special, seq_host_parity, seq_secondary_parity, seq_nxm, seq_buffer_valid;
    term_class_t seq_tc;
    phys_addr_t  seq_end_addr, cmd_pointer;
    logic        cmd_start, subsys_init, auto_load, boot_start, secondary_parity_flag;
    int          err_count   = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    always #4 mclk = ~mclk;

    tape_coupler_status_register #(.ADDR_W(18)) u_dut (
        .mclk(mclk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_init(bus_init), .drive_power_up(drive_power_up),
        .drive_online(drive_online), .load_point(load_point), .attention_message_enable(attention_message_enable),
        .msg_released(msg_released), .seq_done(seq_done), .seq_tc(seq_tc), .seq_special(seq_special),
        .seq_host_parity(seq_host_parity), .seq_secondary_parity(seq_secondary_parity),
        .seq_nxm(seq_nxm), .seq_buffer_valid(seq_buffer_valid), .seq_end_addr(seq_end_addr),
        .cmd_pointer(cmd_pointer), .cmd_start(cmd_start), .subsys_init(subsys_init),
        .auto_load(auto_load), .boot_start(boot_start), .secondary_parity_flag(secondary_parity_flag)
    );

    host_bus_model u_host (
        .mclk(mclk), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        check(u_host.lost, 0);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic wr(input logic [2:0] a, input bus_word_t d);
        u_host.access(1'b1, 1'b0, a, d, rd);
    endtask : wr

    task automatic st();
        u_host.access(1'b0, 1'b0, `STATUS_OFFSET, 16'h0000, rd);
    endtask : st

    task automatic seq_end(input term_class_t tc, input logic sp, input logic err, input phys_addr_t ea);
        @(negedge mclk);
        seq_done             = 1'b1;
        seq_tc               = tc;
        seq_special          = sp;
        seq_host_parity      = err;
        seq_nxm              = err;
        seq_secondary_parity = err;
        seq_end_addr         = ea;
        @(negedge mclk);
        seq_done             = 1'b0;
        seq_tc               = ~tc;
        seq_end_addr         = ~ea;
    endtask : seq_end

    task automatic t_reset();
        st();
        check(rd & 16'hFFBF, 16'h0480);
        u_host.access(1'b0, 1'b0, 3'h4, 16'h0000, rd);
        check(rd, 16'h0000);
    endtask : t_reset

    task automatic t_pointer();
        wr(`DATA_BUF_OFFSET, 16'hABCD);
        check(cmd_start, 1'b1);
        check(cmd_pointer, 18'h1ABCC);
        st();
        check(rd[7], 1'b0);
        wr(`DATA_BUF_OFFSET, 16'h1000);
        check(cmd_start, 1'b0);
        st();
        check({rd[15], rd[12], rd[3:1]}, 5'b11000);
        seq_end(3'h0, 1'b0, 1'b0, 18'h00000);
        wr(`DATA_BUF_OFFSET, 16'h2000);
        st();
        check(rd[15:11], 5'h00);
        seq_end(3'h0, 1'b0, 1'b0, 18'h00000);
    endtask : t_pointer

    task automatic t_classes();
        logic [2:0] c;
        logic       hi;
        for (int i = 0; i < 8; i++) begin
            c  = 3'(i);
            hi = (i >= 4);
            seq_end(c, 1'b1, 1'b1, {c[1:0], 16'h1234});
            st();
            check(rd, {1'b1, hi, 2'b00, hi, 1'b1, c[1:0], 1'b1, 1'b0, 2'b00, c, 1'b0});
            check(u_host.class_of(rd), c);
        end
        check(secondary_parity_flag, 1'b1);
        wr(`DATA_BUF_OFFSET, 16'h0400);
        st();
        check({rd[14], rd[11], secondary_parity_flag}, 3'b000);
        seq_end(3'h0, 1'b0, 1'b0, 18'h00000);
    endtask : t_classes

    task automatic t_stale();
        attention_message_enable  = 1'b0;
        drive_online = 1'b0;
        seq_end(3'h3, 1'b1, 1'b0, 18'h00000);
        st();
        check({rd[6], rd[3:1]}, 4'b0000);
        msg_released = 1'b1;
        seq_end(3'h3, 1'b1, 1'b0, 18'h00000);
        st();
        check({rd[15], rd[6], rd[3:1]}, 5'b11011);
    endtask : t_stale

    task automatic t_buffer();
        @(negedge mclk);
        seq_buffer_valid = 1'b1;
        @(negedge mclk);
        seq_buffer_valid = 1'b0;
        st();
        check(rd[10], 1'b0);
    endtask : t_buffer

    task automatic t_init();
        drive_online = 1'b1;
        wr(`STATUS_OFFSET, 16'h0000);
        check({subsys_init, auto_load}, 2'b11);
        st();
        check({rd[15], rd[7]}, 2'b10);
        @(negedge mclk);
        load_point = 1'b1;
        @(negedge mclk);
        load_point = 1'b0;
        st();
        check(rd, 16'h0480);
        drive_online   = 1'b0;
        drive_power_up = 1'b1;
        @(negedge mclk);
        drive_power_up = 1'b0;
        check({subsys_init, auto_load}, 2'b10);
        st();
        check(rd[7], 1'b1);
    endtask : t_init

    task automatic t_boot();
        @(negedge mclk);
        bus_init = 1'b1;
        @(negedge mclk);
        bus_init = 1'b0;
        wr(`STATUS_OFFSET, `BOOT_VALUE);
        check(boot_start, 1'b0);
        wr(`STATUS_OFFSET, `BOOT_VALUE);
        check(boot_start, 1'b1);
        st();
        check(rd[7], 1'b0);
        seq_end(3'h0, 1'b0, 1'b0, 18'h00000);
        st();
        check(rd[7], 1'b1);
    endtask : t_boot

    // Odd byte write to the data buffer is a maintenance wrap that halts until initialize
    task automatic t_maint();
        u_host.access(1'b1, 1'b1, 3'h1, 16'hA300, rd);
        u_host.access(1'b0, 1'b0, `DATA_BUF_OFFSET, 16'h0000, rd);
        check(rd, 16'hA3A3);
        st();
        check({rd[9:8], rd[7]}, 3'b110);
        wr(`DATA_BUF_OFFSET, 16'h0004);
        check(cmd_start, 1'b0);
        st();
        check({rd[15], rd[12], rd[3:1]}, 5'b11000);
        wr(`STATUS_OFFSET, 16'h0000);
        st();
        check({rd[15], rd[12], rd[9:8], rd[7]}, 5'b00111);
    endtask : t_maint

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    initial begin
        {bus_init, drive_power_up, load_point, msg_released, seq_done} = 5'b00000;
        {seq_special, seq_host_parity, seq_secondary_parity, seq_nxm, seq_buffer_valid} = 5'b00000;
        drive_online = 1'b1;
        attention_message_enable  = 1'b1;
        seq_tc       = 3'h0;
        seq_end_addr = 18'h00000;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_pointer();
        t_classes();
        t_stale();
        t_buffer();
        t_init();
        t_boot();
        t_maint();
        results();
    end
endmodule : test_tape_coupler_status_register
